/* shared/sensor_ctl_defines.vh */
// register offsets, field positions, reset values and codes of the control bank
`ifndef SENSOR_CTL_DEFINES_VH
`define SENSOR_CTL_DEFINES_VH

`define ADDR_DEVICE_CONTROL   8'h0A
`define ADDR_DEVICE_CONFIG    8'h0B

`define CTL_KEY_HI_BIT        7
`define CTL_KEY_LO_BIT        6
`define CTL_PHASE_MSB         5
`define CTL_PHASE_LSB         4
`define CTL_OVERRIDE_BIT      3

`define CFG_SOURCE_BIT        7
`define CFG_INIT_DONE_BIT     5
`define CFG_UNSIGNED_BIT      4
`define CFG_MONITOR_BIT       3
`define CFG_ARM_MSB           2

`define CTL_RESET_VALUE       8'h00
// held control bits 5..0 only; the key bits are never stored
`define CTL_HELD_RESET        6'h00
`define CFG_RESET_VALUE       8'h00
// writable config bits: bit 6 is reserved and stored as zero
`define CFG_WRITE_MASK        8'hBF

`define KEY_STEP1             2'b00
`define KEY_STEP2             2'b11
`define KEY_STEP3             2'b01

`define PHASE_START1          2'b00
`define PHASE_START2          2'b01
`define PHASE_START3          2'b10
`define PHASE_NORMAL          2'b11

`define ARM_HIZ               3'b000
`define ARM_PCM               3'b001
`define ARM_AVG_HI            3'b010
`define ARM_AVG_LO            3'b011
`define ARM_CNT_HI            3'b100
`define ARM_CNT_LO            3'b101
`define ARM_RAW_HI            3'b110
`define ARM_RAW_LO            3'b111

`endif

/* hw/reset_key_tracker.v */
// tracks the three-write software reset key sequence
`timescale 1ns/1ps
`default_nettype none
`include "sensor_ctl_defines.vh"

module reset_key_tracker (
  input  wire       sys_clk,
  input  wire       reset,
  input  wire       clkEn,
  input  wire       cmdValid,
  input  wire       ctlWrite,
  input  wire [1:0] keyBits,
  output reg        keyFire
);

  localparam [1:0] IDLE  = 2'd0;
  localparam [1:0] SEEN1 = 2'd1;
  localparam [1:0] SEEN2 = 2'd2;

  reg [1:0] state;
  reg [1:0] next_state;
  reg       next_keyFire;

  always @* begin
    next_state   = IDLE;
    next_keyFire = 1'b0;
    // any command other than the expected write restarts the sequence
    if (ctlWrite) begin
      case (state)
        IDLE:    next_state = (keyBits == `KEY_STEP1) ? SEEN1 : IDLE;
        SEEN1: begin
          if (keyBits == `KEY_STEP2) next_state = SEEN2;
          else if (keyBits == `KEY_STEP1) next_state = SEEN1;
          else next_state = IDLE;
        end
        SEEN2: begin
          if (keyBits == `KEY_STEP3) next_keyFire = 1'b1;
          else if (keyBits == `KEY_STEP1) next_state = SEEN1;
          else next_state = IDLE;
        end
        default: next_state = IDLE;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      state   <= IDLE;
      keyFire <= 1'b0;
    end else if (clkEn) begin
      keyFire <= next_keyFire;
      if (cmdValid) begin
        state <= next_state;
      end
    end
  end

endmodule // reset_key_tracker
`default_nettype wire

/* hw/arm_mode_decode.v */
// decodes the arming configuration code into pin behaviour
`timescale 1ns/1ps
`default_nettype none
`include "sensor_ctl_defines.vh"

module arm_mode_decode (
  input  wire [2:0] armCode,
  output reg        armPinEnable,
  output reg        armPcmMode,
  output reg        armAvgMode,
  output reg        armCountMode,
  output reg        armRawMode,
  output reg        armActiveLow
);

  always @* begin
    armPinEnable = 1'b1;
    armPcmMode   = 1'b0;
    armAvgMode   = 1'b0;
    armCountMode = 1'b0;
    armRawMode   = 1'b0;
    armActiveLow = armCode[0];
    case (armCode)
      `ARM_HIZ: begin
        armPinEnable = 1'b0;
        armActiveLow = 1'b0;
      end
      `ARM_PCM: begin
        armPcmMode   = 1'b1;
        armActiveLow = 1'b0;
      end
      `ARM_AVG_HI, `ARM_AVG_LO: armAvgMode   = 1'b1;
      `ARM_CNT_HI, `ARM_CNT_LO: armCountMode = 1'b1;
      `ARM_RAW_HI, `ARM_RAW_LO: armRawMode   = 1'b1;
      default: armPinEnable = 1'b0;
    endcase
  end

endmodule // arm_mode_decode
`default_nettype wire

/* hw/sensor_control_config_regs.v */
// control and configuration register bank of the dual-axis sensor
// Functional notes
// - reset fires on three control writes with keys 00, 11, then 01.
// - keys must be back-to-back commands; anything else abandons the sequence.
// - control write response shows zero keys and held bits 5..0.
// - control read returns zero keys and cancels the key sequence.
// - with init complete, bits 2..0 frozen; responses show last written.
// - phase writes accepted only when init clear and override enabled.
// - override holds phase code: start1, start2, start3 or normal.
// - override off resumes normal progression from the phase the override left.
// - after init complete, phase and override writes ignored, phase normal.
// - after init complete neither register is writable; control writes still feed the key tracker.
// - init complete clears only through a device reset.
// - writable-register check runs only while init complete is set.
// - init complete disables self test by masking both request inputs.
// - source select 0 sends offset-cancelled data, 1 sends raw data.
// - source select 0 forces the offset monitor on.
// - format bit 1 unsigned with zero-g at 512, 0 signed.
// - offset monitor enable bit turns the monitor on or off with source select 1.
// - three-bit arming code sets mode and polarity of the arming pin.
// - control at 0x0A: keys 7..6, phase 5..4, override 3, all reset 0.
`timescale 1ns/1ps
`default_nettype none
`include "sensor_ctl_defines.vh"

module sensor_control_config_regs (
  input  wire       sys_clk,
  input  wire       reset,
  input  wire       clkEn,
  input  wire       cmdValid,
  input  wire       cmdWrite,
  input  wire [7:0] cmdAddr,
  input  wire [7:0] cmdData,
  input  wire       phaseAdvance,
  input  wire       selftestXReq,
  input  wire       selftestYReq,
  output reg        rspValid,
  output reg  [7:0] rspData,
  output reg        rspHit,
  output wire       deviceReset,
  output reg  [1:0] offsetCancelPhase,
  output wire       crcCheckEnable,
  output wire       selftestXActive,
  output wire       selftestYActive,
  output wire       sendRawData,
  output wire       unsignedFormat,
  output wire       offsetMonitorOn,
  output wire       armPinEnable,
  output wire       armPcmMode,
  output wire       armAvgMode,
  output wire       armCountMode,
  output wire       armRawMode,
  output wire       armActiveLow
);

  // held control bits 5..0: phase, override enable, reserved 2..0
  reg  [5:0] ctlHeld;
  reg  [7:0] deviceConfig;
  reg        softReset;

  wire       ctlHit  = cmdValid && (cmdAddr == `ADDR_DEVICE_CONTROL);
  wire       cfgHit  = cmdValid && (cmdAddr == `ADDR_DEVICE_CONFIG);
  wire       ctlWr   = ctlHit && cmdWrite;
  wire       cfgWr   = cfgHit && cmdWrite;
  wire       initDone = deviceConfig[`CFG_INIT_DONE_BIT];
  wire       overrideEn = ctlHeld[`CTL_OVERRIDE_BIT];
  wire [1:0] heldPhase  = ctlHeld[`CTL_PHASE_MSB-:2];
  wire       keyFire;
  wire       localReset = reset || softReset;

  wire [1:0] keyBits = {cmdData[`CTL_KEY_HI_BIT], cmdData[`CTL_KEY_LO_BIT]};

  reset_key_tracker keyTracker (
    .sys_clk  (sys_clk),
    .reset    (localReset),
    .clkEn    (clkEn),
    .cmdValid (cmdValid),
    .ctlWrite (ctlWr),
    .keyBits  (keyBits),
    .keyFire  (keyFire)
  );

  assign deviceReset = softReset;

  // one-cycle soft reset pulse after the third key write
  always @(posedge sys_clk) begin
    if (reset) begin
      softReset <= 1'b0;
    end else if (clkEn) begin
      softReset <= keyFire;
    end
  end

  // control register: keys are never stored, they only feed the tracker
  always @(posedge sys_clk) begin
    if (localReset) begin
      ctlHeld <= `CTL_HELD_RESET;
    end else if (clkEn && ctlWr && !initDone) begin
      ctlHeld[`CTL_OVERRIDE_BIT] <= cmdData[`CTL_OVERRIDE_BIT];
      ctlHeld[2:0]               <= cmdData[2:0];
      // phase accepted only with override already enabled
      if (overrideEn) begin
        ctlHeld[`CTL_PHASE_MSB-:2] <= cmdData[`CTL_PHASE_MSB-:2];
      end
    end
  end

  // configuration register locks once init completes
  always @(posedge sys_clk) begin
    if (localReset) begin
      deviceConfig <= `CFG_RESET_VALUE;
    end else if (clkEn && cfgWr && !initDone) begin
      deviceConfig <= cmdData & `CFG_WRITE_MASK;
    end
  end

  // register response, answered the cycle after the command
  always @(posedge sys_clk) begin
    if (reset) begin
      rspValid <= 1'b0;
      rspData  <= 8'h00;
      rspHit   <= 1'b0;
    end else if (clkEn) begin
      rspValid <= cmdValid;
      rspHit   <= ctlHit || cfgHit;
      if (ctlHit) begin
        rspData <= {2'b00, ctlHeld};
      end else if (cfgHit) begin
        rspData <= deviceConfig;
      end else begin
        rspData <= 8'h00;
      end
    end
  end

  // offset cancellation phase sequencer
  always @(posedge sys_clk) begin
    if (localReset) begin
      offsetCancelPhase <= `PHASE_START1;
    end else if (clkEn) begin
      if (initDone) begin
        offsetCancelPhase <= `PHASE_NORMAL;
      end else if (overrideEn) begin
        offsetCancelPhase <= heldPhase;
      end else if (phaseAdvance &&
                   offsetCancelPhase != `PHASE_NORMAL) begin
        // progression continues from the phase left by the override
        offsetCancelPhase <= offsetCancelPhase + 2'd1;
      end
    end
  end

  assign crcCheckEnable  = initDone;
  assign selftestXActive = selftestXReq && !initDone;
  assign selftestYActive = selftestYReq && !initDone;
  assign sendRawData     = deviceConfig[`CFG_SOURCE_BIT];
  assign unsignedFormat  = deviceConfig[`CFG_UNSIGNED_BIT];
  assign offsetMonitorOn = deviceConfig[`CFG_MONITOR_BIT] ||
                           !deviceConfig[`CFG_SOURCE_BIT];

  arm_mode_decode armDecode (
    .armCode      (deviceConfig[`CFG_ARM_MSB:0]),
    .armPinEnable (armPinEnable),
    .armPcmMode   (armPcmMode),
    .armAvgMode   (armAvgMode),
    .armCountMode (armCountMode),
    .armRawMode   (armRawMode),
    .armActiveLow (armActiveLow)
  );

endmodule // sensor_control_config_regs
`default_nettype wire

/* tb/spi_host_model.sv */
// host-side model: issues one register command per call
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic       sys_clk,
  input  wire logic       rspValid,
  output var  logic       cmdValid,
  output var  logic       cmdWrite,
  output var  logic [7:0] cmdAddr,
  output var  logic [7:0] cmdData
);
  logic got;
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdAddr  = 8'h00;
    cmdData  = 8'h00;
  end
  // reserved bits are zeroed; lines scramble after the pulse
  task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdAddr  = a;
    cmdData  = (a == 8'h0A) ? (d & 8'hF8) : (d & 8'hBF);
    @(posedge sys_clk) #1;
    got      = rspValid;
    cmdValid = 1'b0;
    cmdAddr  = ~a;
    cmdData  = ~d;
  endtask
endmodule // spi_host_model
`default_nettype wire

/* tb/sensor_ctl_assertions.sv */
// port-level assertions for the control bank
`timescale 1ns/1ps
`default_nettype none
module sensor_ctl_checker (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       clkEn,
  input wire logic       cmdValid,
  input wire logic [7:0] cmdAddr,
  input wire logic       selftestXReq,
  input wire logic       rspValid,
  input wire logic [7:0] rspData,
  input wire logic       rspHit,
  input wire logic       deviceReset,
  input wire logic [1:0] offsetCancelPhase,
  input wire logic       crcCheckEnable,
  input wire logic       selftestXActive,
  input wire logic       sendRawData,
  input wire logic       offsetMonitorOn,
  input wire logic       armPinEnable,
  input wire logic       armPcmMode,
  input wire logic       armAvgMode,
  input wire logic       armCountMode,
  input wire logic       armRawMode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  rsp_timing_a: assert property (clkEn && cmdValid |=> rspValid)
    else $error("no response");
  rsp_only_a: assert property (!(clkEn && cmdValid) |=> !rspValid)
    else $error("stray response");
  key_zero_a: assert property (cmdValid && cmdAddr == 8'h0A
    |=> rspData[7:6] == 2'b00) else $error("key bits not zero");
  unmapped_hit_a: assert property (cmdValid && cmdAddr[7:1] != 7'h05
    |=> !rspHit && rspData == 8'h00) else $error("unmapped hit");
  init_sticky_a: assert property (crcCheckEnable
    |=> crcCheckEnable || $past(deviceReset)) else $error("init cleared");
  phase_forced_a: assert property ($past(crcCheckEnable) && crcCheckEnable
    |-> offsetCancelPhase == 2'b11) else $error("phase not normal");
  selftest_off_a: assert property (selftestXActive
    == (selftestXReq && !crcCheckEnable)) else $error("self test");
  monitor_force_a: assert property (!sendRawData |-> offsetMonitorOn)
    else $error("monitor off");
  key_pulse_a: assert property (deviceReset
    |=> !deviceReset && !crcCheckEnable) else $error("key reset");
  arm_enable_a: assert property (armPinEnable == (armPcmMode
    || armAvgMode || armCountMode || armRawMode)) else $error("arm pins");
endmodule // sensor_ctl_checker
bind sensor_control_config_regs sensor_ctl_checker i_sensor_ctl_checker (.*);
`default_nettype wire

/* tb/tb_sensor_control_config_regs.sv */
// self-checking bench for the control and configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "sensor_ctl_defines.vh"
module tb_sensor_control_config_regs;
  logic       sys_clk, reset, clkEn, phaseAdvance, selftestXReq, selftestYReq;
  logic       cmdValid, cmdWrite, rspValid, rspHit, deviceReset, sendRawData;
  logic [7:0] cmdAddr, cmdData, rspData;
  logic [1:0] offsetCancelPhase;
  logic       crcCheckEnable, selftestXActive, selftestYActive, armRawMode;
  logic       unsignedFormat, offsetMonitorOn, armPinEnable, armPcmMode;
  logic       armAvgMode, armCountMode, armActiveLow;
  int         fail_count, checked;
  sensor_control_config_regs i_sensor_control_config_regs (.*);
  spi_host_model i_spi_host_model (.sys_clk(sys_clk), .rspValid(rspValid),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
    .cmdData(cmdData));
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    i_spi_host_model.cmd(w, a, d);
    chk(i_spi_host_model.got, 1'b1);
    if (i_spi_host_model.got !== 1'b1) close_out();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    op(1'b0, a, 8'h00);
    chk(rspData, e);
  endtask
  // a zero mid address means no command between the first two keys
  task automatic key_seq(input logic [7:0] mid, input logic fire);
    logic seen;
    seen = 1'b0;
    op(1'b1, 8'h0A, 8'h00);
    if (mid != 8'h00) op(1'b0, mid, 8'h00);
    op(1'b1, 8'h0A, 8'hC0);
    op(1'b1, 8'h0A, 8'h40);
    repeat (6) @(posedge sys_clk) #1 seen |= deviceReset;
    chk(seen, fire);
    if (fire && !seen) close_out();
  endtask
  task automatic t_reset;
    rd(`ADDR_DEVICE_CONTROL, `CTL_RESET_VALUE);
    rd(`ADDR_DEVICE_CONFIG, `CFG_RESET_VALUE);
    rd(8'h0C, 8'h00);
    chk(rspHit, 1'b0);
    chk(crcCheckEnable, 1'b0);
    chk(selftestXActive, 1'b1);
  endtask
  task automatic t_config;
    for (int c = 0; c < 8; c++) begin
      op(1'b1, `ADDR_DEVICE_CONFIG, {5'b10011, c[2:0]});
      chk(armPinEnable, c != 0);
      chk(armPcmMode, c == 1);
      chk(armAvgMode, c[2:1] == 2'd1);
      chk(armCountMode, c[2:1] == 2'd2);
      chk(armRawMode, c[2:1] == 2'd3);
      if (c > 1) chk(armActiveLow, c[0]);
    end
    rd(`ADDR_DEVICE_CONFIG, 8'h9F);
    chk({sendRawData, unsignedFormat}, 2'b11);
    op(1'b1, `ADDR_DEVICE_CONFIG, 8'h80);
    chk(offsetMonitorOn, 1'b0);
    op(1'b1, `ADDR_DEVICE_CONFIG, 8'h00);
    chk({sendRawData, unsignedFormat, offsetMonitorOn}, 3'b001);
  endtask
  task automatic t_phase;
    op(1'b1, 8'h0A, 8'h20);
    chk(offsetCancelPhase, `PHASE_START1);
    op(1'b1, 8'h0A, 8'h08);
    for (int p = 0; p < 4; p++) begin
      op(1'b1, 8'h0A, {2'b00, p[1:0], 4'h8});
      // the sequencer follows the held phase one cycle after the write
      @(posedge sys_clk) #1;
      chk(offsetCancelPhase, p[1:0]);
    end
    op(1'b1, 8'h0A, 8'h18);
    op(1'b1, 8'h0A, 8'h10);
    phaseAdvance = 1'b1;
    @(posedge sys_clk) #1 phaseAdvance = 1'b0;
    chk(offsetCancelPhase, `PHASE_START3);
  endtask
  task automatic t_lock;
    op(1'b1, 8'h0A, 8'h18);
    op(1'b1, `ADDR_DEVICE_CONFIG, 8'h20);
    @(posedge sys_clk) #1;
    chk({crcCheckEnable, offsetCancelPhase}, 3'b111);
    chk({selftestXActive, selftestYActive}, 2'b00);
    op(1'b1, `ADDR_DEVICE_CONFIG, 8'h00);
    rd(`ADDR_DEVICE_CONFIG, 8'h20);
    op(1'b1, 8'h0A, 8'h28);
    chk(rspData, 8'h18);
    rd(8'h0A, 8'h18);
    key_seq(8'h00, 1'b1);
    rd(`ADDR_DEVICE_CONFIG, 8'h00);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    {reset, clkEn, selftestXReq, selftestYReq} = 4'hF;
    phaseAdvance = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (20) @(posedge sys_clk);
    #1 reset = 1'b0;
    t_reset();
    $display("reset test done");
    key_seq(8'h00, 1'b1);
    key_seq(8'h0A, 1'b0);
    key_seq(8'h0B, 1'b0);
    $display("key test done");
    t_config();
    $display("config test done");
    t_phase();
    $display("phase test done");
    t_lock();
    $display("lock test done");
    close_out();
  end
endmodule // tb_sensor_control_config_regs
`default_nettype wire
